// >>> srh_ctrl.sv
`include "srh_defs.svh"
`default_nettype none
module srh_ctrl
   import srh_pkg::*;
#(
   parameter int ADDR_W = 15,
   parameter int DATA_W = 8
) (
   input  wire logic              mclk,
   input  wire logic              rst_b,
   input  wire logic              req,
   input  wire logic              req_write,
   input  wire logic [ADDR_W-1:0] req_addr,
   input  wire logic [DATA_W-1:0] req_wdata,
   input  wire logic              retain,
   output logic                   busy,
   output logic                   rd_valid,
   output logic [DATA_W-1:0]      rd_data,
   output logic [ADDR_W-1:0]      word_address_lines,
   input  wire logic [DATA_W-1:0] byte_data_pins_in,
   output logic [DATA_W-1:0]      byte_data_pins_out,
   output logic                   byte_data_pins_oe_b,
   output logic                   chip_sel_b,
   output logic                   out_en_b,
   output logic                   rd_wr_sel
);
   // ------------------------------------------------------------
   // Timing counts
   // ------------------------------------------------------------
   localparam logic [`SRH_CNT_W-1:0] RD_CYC  = `SRH_CNT_W'(`SRH_TRC_CYC + `SRH_TOE_CYC);
   localparam logic [`SRH_CNT_W-1:0] WR_CYC  = `SRH_CNT_W'(`SRH_TCW_CYC);
   localparam logic [`SRH_CNT_W-1:0] GAP_CYC = `SRH_CNT_W'(`SRH_TRC_CYC);
   localparam logic [`SRH_CNT_W-1:0] TURN_CYC = `SRH_CNT_W'(`SRH_TODO_CYC);

   srh_state_e            state_reg;
   logic [`SRH_CNT_W-1:0] cnt_reg;
   logic                  retain_d_reg;

   // ------------------------------------------------------------
   // Access sequencer
   // ------------------------------------------------------------
   // Pins and state move together from one process
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         state_reg           <= SRH_IDLE;
         cnt_reg             <= '0;
         busy                <= 1'b1;
         rd_valid            <= 1'b0;
         rd_data             <= '0;
         word_address_lines  <= '0;
         byte_data_pins_out  <= '0;
         byte_data_pins_oe_b <= 1'b1;
         chip_sel_b          <= 1'b1;
         out_en_b            <= 1'b1;
         rd_wr_sel           <= 1'b1;
         retain_d_reg        <= 1'b1;
      end else begin
         rd_valid     <= 1'b0;
         retain_d_reg <= retain;
         unique case (state_reg)
            SRH_IDLE: begin
               if (retain) begin
                  chip_sel_b <= 1'b1; // Deselect at once
                  busy       <= 1'b1;
               end else if (retain_d_reg) begin
                  state_reg <= SRH_GAP; // Recovery wait
                  cnt_reg   <= GAP_CYC;
               end else if (req) begin
                  busy               <= 1'b1;
                  word_address_lines <= req_addr;
                  chip_sel_b         <= 1'b0;
                  cnt_reg            <= req_write ? WR_CYC : RD_CYC;
                  if (req_write) begin
                     rd_wr_sel           <= 1'b0; // Write select falls with select
                     out_en_b            <= 1'b1;
                     byte_data_pins_out  <= req_wdata;
                     byte_data_pins_oe_b <= 1'b0; // Memory already floated
                     state_reg           <= SRH_WR;
                  end else begin
                     rd_wr_sel <= 1'b1;
                     out_en_b  <= 1'b0;
                     state_reg <= SRH_RD;
                  end
               end else begin
                  busy <= 1'b0;
               end
            end
            SRH_RD: begin
               if (cnt_reg == `SRH_CNT_W'(1)) begin
                  rd_data   <= byte_data_pins_in; // Data valid by now
                  rd_valid  <= 1'b1;
                  out_en_b  <= 1'b1;
                  chip_sel_b <= 1'b1;
                  cnt_reg   <= TURN_CYC;
                  state_reg <= SRH_RD_END;
               end else begin
                  cnt_reg <= cnt_reg - `SRH_CNT_W'(1);
               end
            end
            SRH_RD_END: begin
               // Bus turnaround while memory releases
               if (cnt_reg == `SRH_CNT_W'(1)) begin
                  state_reg <= SRH_GAP;
                  cnt_reg   <= GAP_CYC;
               end else begin
                  cnt_reg <= cnt_reg - `SRH_CNT_W'(1);
               end
            end
            SRH_WR: begin
               if (cnt_reg == `SRH_CNT_W'(1)) begin
                  chip_sel_b <= 1'b1; // Select ends write, held long enough
                  state_reg  <= SRH_WR_END;
               end else begin
                  cnt_reg <= cnt_reg - `SRH_CNT_W'(1);
               end
            end
            SRH_WR_END: begin
               rd_wr_sel           <= 1'b1; // After select rose
               byte_data_pins_oe_b <= 1'b1;
               state_reg           <= SRH_GAP;
               cnt_reg             <= GAP_CYC;
            end
            SRH_GAP: begin
               // Spacing between accesses
               if (cnt_reg <= `SRH_CNT_W'(1)) begin
                  state_reg <= SRH_IDLE;
               end else begin
                  cnt_reg <= cnt_reg - `SRH_CNT_W'(1);
               end
            end
            default: state_reg <= SRH_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Pin protocol checks
   // ------------------------------------------------------------
   // Host drive only while the memory is held off
   a_no_contention: assert property (@(posedge mclk) disable iff (!rst_b)
      !byte_data_pins_oe_b |-> (out_en_b && !rd_wr_sel))
      else $error("Host drives data while memory may drive");
   // Selected read keeps the write select high
   a_read_rw_high: assert property (@(posedge mclk) disable iff (!rst_b)
      (!chip_sel_b && !out_en_b) |-> rd_wr_sel)
      else $error("Read/write select low during read");
   // Output enable parked through writes
   a_write_oe_high: assert property (@(posedge mclk) disable iff (!rst_b)
      !rd_wr_sel |-> out_en_b)
      else $error("Output enable low during write");
   // Write select falls only while deselected
   a_cs_after_rw: assert property (@(posedge mclk) disable iff (!rst_b)
      $fell(rd_wr_sel) |-> $past(chip_sel_b))
      else $error("Select fell before write select");
   // Write select returns only after deselect
   a_cs_rise_first: assert property (@(posedge mclk) disable iff (!rst_b)
      $rose(rd_wr_sel) |-> $past(chip_sel_b))
      else $error("Write select rose while selected");
   // Idle leaves every control pin parked
   a_idle_quiet: assert property (@(posedge mclk) disable iff (!rst_b)
      (state_reg == SRH_IDLE) |-> (chip_sel_b && out_en_b && rd_wr_sel && byte_data_pins_oe_b))
      else $error("Pins active while idle");
   // A selected memory always belongs to an access
   a_busy_access: assert property (@(posedge mclk) disable iff (!rst_b)
      !chip_sel_b |-> busy)
      else $error("Chip selected while not busy");

   // ------------------------------------------------------------
   // Timing checks
   // ------------------------------------------------------------
   // Whole selected cycle with data before a write ends
   a_write_width: assert property (@(posedge mclk) disable iff (!rst_b)
      ($rose(chip_sel_b) && !rd_wr_sel) |-> (!$past(chip_sel_b) && !$past(byte_data_pins_oe_b)))
      else $error("Write select window too short");
   // Read data taken two cycles after enable
   a_read_valid: assert property (@(posedge mclk) disable iff (!rst_b)
      $fell(out_en_b) |-> ##2 rd_valid)
      else $error("Read data not taken in time");
   // Host holds off while the memory releases
   a_read_release: assert property (@(posedge mclk) disable iff (!rst_b)
      $rose(out_en_b) |-> byte_data_pins_oe_b ##1 byte_data_pins_oe_b)
      else $error("Host drives during memory release");
   // Address held through each access
   a_addr_held: assert property (@(posedge mclk) disable iff (!rst_b)
      (!chip_sel_b && !$fell(chip_sel_b)) |-> $stable(word_address_lines))
      else $error("Address moved during access");
   // Deselected gap between accesses
   a_gap_spacing: assert property (@(posedge mclk) disable iff (!rst_b)
      $rose(chip_sel_b) |=> chip_sel_b [*2])
      else $error("Accesses too close");
   // Retention deselects at once
   a_retain_desel: assert property (@(posedge mclk) disable iff (!rst_b)
      (retain && state_reg == SRH_IDLE) |=> chip_sel_b)
      else $error("Not deselected for retention");
   // Recovery gap after retention ends
   a_retain_recov: assert property (@(posedge mclk) disable iff (!rst_b)
      (state_reg == SRH_IDLE && retain_d_reg && !retain) |=> chip_sel_b [*2])
      else $error("Access too soon after retention");

   // ------------------------------------------------------------
   // Coverage
   // ------------------------------------------------------------
   c_read: cover property (@(posedge mclk) disable iff (!rst_b) rd_valid);
   c_write: cover property (@(posedge mclk) disable iff (!rst_b) $rose(rd_wr_sel));
   c_retain: cover property (@(posedge mclk) disable iff (!rst_b) $fell(retain));
   c_write_end: cover property (@(posedge mclk) disable iff (!rst_b) $rose(chip_sel_b) && !rd_wr_sel);
   c_recovery: cover property (@(posedge mclk) disable iff (!rst_b) state_reg == SRH_IDLE && retain_d_reg && !retain);
endmodule
`default_nettype wire

// >>> srh_defs.svh
`ifndef SRH_DEFS_SVH
`define SRH_DEFS_SVH
// ------------------------------------------------------------
// Timing figures in ns and derived cycle counts
// ------------------------------------------------------------
`define SRH_CLK_NS        100
`define SRH_TRC_NS        85
`define SRH_TCW_NS        65
`define SRH_TOE_NS        45
`define SRH_TODO_NS       30
`define SRH_TRC_CYC       ((`SRH_TRC_NS + `SRH_CLK_NS - 1) / `SRH_CLK_NS)
`define SRH_TCW_CYC       ((`SRH_TCW_NS + `SRH_CLK_NS - 1) / `SRH_CLK_NS)
`define SRH_TOE_CYC       ((`SRH_TOE_NS + `SRH_CLK_NS - 1) / `SRH_CLK_NS)
`define SRH_TODO_CYC      ((`SRH_TODO_NS + `SRH_CLK_NS - 1) / `SRH_CLK_NS)
`define SRH_CNT_W         4
`endif

// >>> srh_pkg.sv
`default_nettype none
package srh_pkg;
   typedef enum logic [2:0] {SRH_IDLE, SRH_RD, SRH_RD_END, SRH_WR, SRH_WR_END, SRH_GAP} srh_state_e;
endpackage
`default_nettype wire

// >>> srh_sram_model.sv
`default_nettype none
module srh_sram_model (
   input  wire logic [14:0] a,
   input  wire logic [7:0]  d_in,
   input  wire logic        cs_b,
   input  wire logic        oe_b,
   input  wire logic        rw,
   output logic      [7:0]  q,
   output logic             drv
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] mem [0:32767];
   logic [7:0] last = 8'h5a;
   // Drive only when selected, enabled and reading
   assign drv = !cs_b && !oe_b && rw;
   // Released pins show the inverse of the last byte
   always @* if (drv) last = mem[a];
   assign q = drv ? mem[a] : ~last;
   // Byte stored at the end of a selected write
   always @(posedge cs_b or posedge rw) if (!rw || !cs_b) mem[a] <= d_in;
endmodule
`default_nettype wire

// >>> test_async_sram_32k_by_8.sv
`default_nettype none
module test_async_sram_32k_by_8;
   timeunit 1ns;
   timeprecision 1ns;
   logic        mclk = 1'b0, rst_b = 1'b0, req = 1'b0, req_write = 1'b0, retain = 1'b0;
   logic [14:0] req_addr = 15'h0000, wla;
   logic [7:0]  req_wdata = 8'h00, rd_data, pins_out, mem_q, bus;
   logic        busy, rd_valid, oe_b, cs_b, out_b, rw, drv;
   logic [7:0]  ref_mem [0:32767];
   logic [31:0] rng = 32'h0000004c;
   int          fails = 0, compares = 0, n;
   always #50 mclk = ~mclk;
   srh_ctrl dut (.mclk(mclk), .rst_b(rst_b), .req(req), .req_write(req_write), .req_addr(req_addr),
      .req_wdata(req_wdata), .retain(retain), .busy(busy), .rd_valid(rd_valid), .rd_data(rd_data),
      .word_address_lines(wla), .byte_data_pins_in(bus), .byte_data_pins_out(pins_out),
      .byte_data_pins_oe_b(oe_b), .chip_sel_b(cs_b), .out_en_b(out_b), .rd_wr_sel(rw));
   srh_sram_model mem (.a(wla), .d_in(bus), .cs_b(cs_b), .oe_b(out_b), .rw(rw), .q(mem_q), .drv(drv));
   // Shared data bus: host when it drives, memory side otherwise
   assign bus = oe_b ? mem_q : pins_out;
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wrap_up();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // Bounded wait for idle or for read data
   task automatic wait_sig(input logic idle);
      n = 0;
      while ((idle ? busy !== 1'b0 : rd_valid !== 1'b1) && n < 30) begin
         @(negedge mclk);
         n++;
      end
      if (idle ? busy !== 1'b0 : rd_valid !== 1'b1) begin
         fails++;
         wrap_up();
      end
   endtask
   // One access, with reference update or read compare
   task automatic access(input logic w, input logic [14:0] a, input logic [7:0] d);
      wait_sig(1'b1);
      req = 1'b1;
      req_write = w;
      req_addr = a;
      req_wdata = d;
      @(negedge mclk);
      req = 1'b0;
      chk({cs_b, rw, oe_b, out_b, wla}, {1'b0, ~w, ~w, w, a});
      if (w) ref_mem[a] = d;
      else begin
         wait_sig(1'b0);
         chk(rd_data, ref_mem[a]);
      end
   endtask
   // No host drive while the memory drives
   always @(negedge mclk) if (rst_b && !oe_b) chk(drv, 1'b0);
   initial begin
      repeat (16) @(negedge mclk);
      rst_b = 1'b1;
      // Corners: lowest and highest byte, back to back
      access(1'b1, 15'h0000, 8'ha5);
      access(1'b1, 15'h7fff, 8'h5a);
      access(1'b0, 15'h0000, 8'h00);
      access(1'b0, 15'h7fff, 8'h00);
      $display("test corners done");
      for (int i = 0; i < 300; i++) begin
         rng = xs(rng);
         access(rng[31] | $isunknown(ref_mem[{rng[30], 10'h000, rng[19:16]}]), {rng[30], 10'h000, rng[19:16]},
            rng[7:0]);
      end
      $display("test random done");
      // Retention: request held off, then recovery gap
      wait_sig(1'b1);
      retain = 1'b1;
      req = 1'b1;
      req_write = 1'b0;
      req_addr = 15'h7fff;
      repeat (5) begin
         @(negedge mclk);
         chk(cs_b, 1'b1);
      end
      retain = 1'b0;
      n = 0;
      while (cs_b !== 1'b0 && n < 20) begin
         @(negedge mclk);
         n++;
      end
      req = 1'b0;
      chk(n >= 2 && n < 20, 1'b1);
      wait_sig(1'b0);
      chk(rd_data, 8'h5a);
      $display("test retention done");
      // Mid-run reset: pins parked, contents kept
      rst_b = 1'b0;
      repeat (2) @(negedge mclk);
      chk({busy, rd_valid, cs_b, out_b, rw, oe_b, rd_data}, 14'h2f00);
      rst_b = 1'b1;
      access(1'b0, 15'h7fff, 8'h00);
      $display("test reset done");
      wrap_up();
   end
endmodule
`default_nettype wire
